// File: flash_query_readout.sv
// read-side query and block-status output path of the flash device
//
// Function
// - query bytes are driven only on the low eight data lines.
// - the upper data byte of every query location reads zero.
// - query offsets are word addresses; the identification table starts at 10h.
// - multi-byte fields put the least significant byte at the lowest address.
// - locations 10h, 11h, 12h return 51h, 52h, 59h.
// - identification at 10h, system interface at 1Bh, geometry at 27h.
// - offsets 4h to Fh are reserved for vendor content.
// - after the query command, partition reads return the query database.
// - each block has a status byte at its base word address plus two.
// - status bit 0 reads one when the block is locked.
// - status bit 1 reads one when the block is locked down.
// - status bits 2 to 7 always read zero.
// - the two-byte field at offset 15h points to the primary extended table.
// - each partition keeps its output mode until a new command changes it.
// - all partitions start in array read mode after reset.
`timescale 1ns/10ps
module flash_query_readout
    import fqr_pkg::*;
#(
    parameter int N_BLK = 128,
    parameter int BLK_W = 7,
    parameter int N_PART = 16,
    parameter int PART_W = 4
)(
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              ce_n_i,
    input  wire logic              oe_n_i,
    input  wire logic              we_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] dq_i,
    input  wire logic [DATA_W-1:0] array_data_i,
    input  wire logic [7:0]        wsm_status_i,
    input  wire logic [N_BLK-1:0]  block_lock_i,
    input  wire logic [N_BLK-1:0]  block_lockdown_i,
    output logic      [DATA_W-1:0] dq_o,
    output logic                   dq_oe_o,
    output logic                   cmd_taken_o
);

    fqr_ctl_s               ctl;
    logic                   wr_armed_r;
    logic                   wr_take;
    logic                   rd_take;
    logic      [PART_W-1:0] part_sel;
    logic      [BLK_W-1:0]  blk_sel;
    logic      [OFS_W-1:0]  q_ofs;
    logic                   in_status_slot;
    logic                   ofs_above_table;
    fqr_mode_e              rd_mode;
    logic      [7:0]        rom_byte;
    logic      [7:0]        block_status_byte;
    fqr_word_s              word_nxt;
    fqr_word_s              word_r;
    logic                   oe_r;
    logic                   cmd_taken_r;

    assign ctl = '{ce_n: ce_n_i, oe_n: oe_n_i, we_n: we_n_i};

    // a write is taken once per low phase of the write strobe
    assign wr_take = !ctl.ce_n && !ctl.we_n && wr_armed_r;
    assign rd_take = !ctl.ce_n && !ctl.oe_n && ctl.we_n;

    assign part_sel = addr_i[ADDR_W-1 -: PART_W];
    assign blk_sel  = addr_i[ADDR_W-1 -: BLK_W];

    // offset inside the block, in words of the full x16 bus
    assign q_ofs           = addr_i[OFS_W-1:0];
    assign ofs_above_table = |addr_i[BLK_SHIFT-1:OFS_W];
    assign in_status_slot  = !ofs_above_table && q_ofs == OFS_BLK_STATUS;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            wr_armed_r <= 1'b1;
        else if (ctl.ce_n || ctl.we_n)
            wr_armed_r <= 1'b1;
        else
            wr_armed_r <= 1'b0;
    end

    fqr_part_mode #(
        .N_PART (N_PART),
        .PART_W (PART_W)
    ) u_part_mode (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .wr_en_i   (wr_take),
        .wr_part_i (part_sel),
        .wr_cmd_i  (dq_i[7:0]),
        .rd_part_i (part_sel),
        .rd_mode_o (rd_mode)
    );

    // the database is a constant table with no write path
    fqr_query_rom u_query_rom (
        .ofs_i  (q_ofs),
        .byte_o (rom_byte)
    );

    always_comb
    begin
        block_status_byte               = 8'h00;
        block_status_byte[LOCK_BIT]     = block_lock_i[blk_sel];
        block_status_byte[LOCKDOWN_BIT] = block_lockdown_i[blk_sel];
    end

    always_comb
    begin
        word_nxt = '{hi_byte: 8'h00, lo_byte: 8'h00};
        unique case (rd_mode)
            FQR_ARRAY:
            begin
                word_nxt = array_data_i;
            end
            FQR_QUERY:
            begin
                word_nxt.hi_byte = UPPER_FILL;
                if (ofs_above_table)
                    word_nxt.lo_byte = 8'h00;
                else if (in_status_slot)
                    word_nxt.lo_byte = block_status_byte;
                else
                    word_nxt.lo_byte = rom_byte;
            end
            FQR_STATUS:
            begin
                word_nxt.hi_byte = 8'h00;
                word_nxt.lo_byte = wsm_status_i;
            end
            default:
            begin
                word_nxt = '{hi_byte: 8'h00, lo_byte: 8'h00};
            end
        endcase
    end

    // data is launched the cycle after the read strobe is seen, so all
    // address decode has a full cycle before reaching the pins
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            word_r <= '{hi_byte: 8'h00, lo_byte: 8'h00};
        else if (rd_take)
            word_r <= word_nxt;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            oe_r <= 1'b0;
        else
            oe_r <= rd_take;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            cmd_taken_r <= 1'b0;
        else
            cmd_taken_r <= wr_take;
    end

    assign dq_o        = word_r;
    assign dq_oe_o     = oe_r;
    assign cmd_taken_o = cmd_taken_r;

endmodule : flash_query_readout

// File: flash_query_readout_tb.sv
// self-checking bench of the flash query read-out block
`timescale 1ns/10ps
module flash_query_readout_tb;
    import fqr_pkg::*;
    logic         clk = 1'b0, reset = 1'b1, req = 1'b0, wr = 1'b0;
    logic [21:0]  req_addr = '0, addr;
    logic [15:0]  req_data = '0, dq_w, array_data = '0, dq_o, e;
    logic [7:0]   wsm_status = '0;
    logic [127:0] lock = '0, lockdn = '0;
    logic [31:0]  seed = 32'ha8c9;
    logic [6:0]   b;
    logic         dq_oe, cmd_taken;
    fqr_ctl_s     ctl;
    int           miscompares = 0, checks_done = 0, cycles = 0;
    logic [7:0]   cmds [4] = '{CMD_QUERY, CMD_READ_ID, CMD_READ_STATUS, CMD_READ_ARRAY};
    logic [7:0]   ofs [10] = '{8'h02, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h1B, 8'h27};
    fqr_host_model u_fqr_host_model (.clk_i(clk), .reset_i(reset), .req_i(req), .wr_i(wr),
        .req_addr_i(req_addr), .req_data_i(req_data), .ctl_o(ctl), .addr_o(addr), .dq_o(dq_w));
    flash_query_readout u_flash_query_readout (.clk_i(clk), .reset_i(reset), .ce_n_i(ctl.ce_n),
        .oe_n_i(ctl.oe_n), .we_n_i(ctl.we_n), .addr_i(addr), .dq_i(dq_w), .array_data_i(array_data),
        .wsm_status_i(wsm_status), .block_lock_i(lock), .block_lockdown_i(lockdn), .dq_o(dq_o),
        .dq_oe_o(dq_oe), .cmd_taken_o(cmd_taken));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    function automatic logic [15:0] q_exp(input logic [7:0] o, input logic [1:0] st);
        case (o)
            8'h02: return {14'h0000, st};
            8'h10: return 16'h0051;
            8'h11: return 16'h0052;
            8'h12: return 16'h0059;
            8'h13: return 16'h0003;
            8'h15: return 16'h0039;
            8'h1B: return 16'h0017;
            default: return 16'h0000;
        endcase
    endfunction : q_exp
    // one host request; side inputs are re-randomised with it and stay put until the next
    task automatic bus(input logic w, input logic [21:0] a, input logic [15:0] d);
        @(posedge clk);
        seed = xs(seed);
        req <= 1'b1;
        wr <= w;
        req_addr <= a;
        req_data <= d;
        array_data <= seed[15:0];
        wsm_status <= seed[23:16];
        lock <= {4{seed}};
        lockdn <= {4{xs(seed)}};
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        #1;
        checks_done++;
        if ({dq_oe, cmd_taken} !== {!w, w})
        begin
            miscompares++;
            $display("MISMATCH strobes at %h expected %b seen %b", a, {!w, w}, {dq_oe, cmd_taken});
        end
    endtask : bus
    task automatic check(input logic [15:0] exp);
        checks_done++;
        if (dq_o !== exp)
        begin
            miscompares++;
            $display("MISMATCH dq_o at %h expected %h seen %h", req_addr, exp, dq_o);
        end
    endtask : check
    task automatic complete_run();
        if (miscompares == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    initial
    begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            complete_run();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            bus(1'b0, seed[31:10], 16'h0000);
            check(array_data);
        end
        // commands go to partition 5 only, so partition 10 must stay in array mode
        for (int c = 0; c < 4; c++)
        begin
            seed = xs(seed);
            b = {4'h5, seed[2:0]};
            bus(1'b1, {b, 15'h0000}, {8'h00, cmds[c]});
            bus(1'b1, {b, 15'h0010}, 16'h0000);
            for (int k = 0; k < 10; k++)
            begin
                bus(1'b0, {b, 7'h00, ofs[k]}, 16'h0000);
                e = c < 2 ? q_exp(ofs[k], {lockdn[b], lock[b]}) : c == 2 ? {8'h00, wsm_status} : array_data;
                check(e);
            end
            bus(1'b0, {4'hA, seed[17:0]}, 16'h0000);
            check(array_data);
        end
        complete_run();
    end
endmodule : flash_query_readout_tb
bind flash_query_readout fqr_chk #(.N_BLK(N_BLK)) u_fqr_chk (.clk_i(clk_i), .reset_i(reset_i),
    .ce_n_i(ce_n_i), .oe_n_i(oe_n_i), .we_n_i(we_n_i), .addr_i(addr_i), .dq_i(dq_i),
    .array_data_i(array_data_i), .block_lock_i(block_lock_i), .block_lockdown_i(block_lockdown_i),
    .dq_o(dq_o), .dq_oe_o(dq_oe_o), .cmd_taken_o(cmd_taken_o));

// File: fqr_chk.sv
// pin-level assertions of the query read-out block
`timescale 1ns/10ps
module fqr_chk
    import fqr_pkg::*;
#(
    parameter int N_BLK = 128
)(
    input wire logic              clk_i,
    input wire logic              reset_i,
    input wire logic              ce_n_i,
    input wire logic              oe_n_i,
    input wire logic              we_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] dq_i,
    input wire logic [DATA_W-1:0] array_data_i,
    input wire logic [N_BLK-1:0]  block_lock_i,
    input wire logic [N_BLK-1:0]  block_lockdown_i,
    input wire logic [DATA_W-1:0] dq_o,
    input wire logic              dq_oe_o,
    input wire logic              cmd_taken_o
);
    logic [15:0] amode_r;
    logic [15:0] qmode_r;
    logic        prev_r;
    logic        rd;
    logic        wr;
    logic        qr;
    logic [3:0]  pt;
    logic [14:0] ofs;
    assign pt  = addr_i[21:18];
    assign ofs = addr_i[14:0];
    assign rd  = !ce_n_i && !oe_n_i && we_n_i;
    assign wr  = !ce_n_i && !we_n_i && prev_r;
    assign qr  = rd && qmode_r[pt];
    always_ff @(posedge clk_i)
    begin
        prev_r <= reset_i || ce_n_i || we_n_i;
    end
    // shadow of the per-partition mode; unknown codes leave it alone
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            amode_r <= '1;
            qmode_r <= '0;
        end
        else if (wr && (dq_i[7:0] inside {CMD_READ_ARRAY, CMD_READ_ID, CMD_QUERY, CMD_READ_STATUS}))
        begin
            amode_r[pt] <= dq_i[7:0] == CMD_READ_ARRAY;
            qmode_r[pt] <= dq_i[7:0] == CMD_READ_ID || dq_i[7:0] == CMD_QUERY;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    AST_RD_OE: assert property (rd |=> dq_oe_o) else $error("no output enable after read");
    AST_NO_RD: assert property (!rd |=> !dq_oe_o && $stable(dq_o)) else $error("output moved without read");
    AST_CMD: assert property (wr |=> cmd_taken_o ##1 !cmd_taken_o) else $error("command pulse wrong");
    AST_ARRAY: assert property (rd && amode_r[pt] |=> dq_o == $past(array_data_i))
        else $error("array word wrong");
    AST_UPPER: assert property (qr |=> dq_o[15:8] == UPPER_FILL) else $error("upper byte not zero");
    AST_SIG: assert property (qr && ofs inside {15'h10, 15'h11, 15'h12} |=> dq_o[7:0] ==
        ($past(ofs[1:0]) == 2'd0 ? 8'h51 : $past(ofs[1:0]) == 2'd1 ? 8'h52 : 8'h59))
        else $error("signature byte wrong");
    AST_PTR: assert property (qr && (ofs == 15'h15 || ofs == 15'h16) |=> dq_o[7:0] ==
        ($past(ofs[0]) ? 8'h39 : 8'h00)) else $error("table pointer wrong");
    AST_CMDSET: assert property (qr && (ofs == 15'h13 || ofs == 15'h14) |=> dq_o[7:0] ==
        ($past(ofs[0]) ? 8'h03 : 8'h00)) else $error("command set id wrong");
    AST_BSR: assert property (qr && ofs == 15'h02 |=> dq_o == {14'h0000,
        $past(block_lockdown_i[addr_i[21:15]]), $past(block_lock_i[addr_i[21:15]])})
        else $error("block status wrong");
endmodule : fqr_chk

// File: fqr_host_model.sv
// host-side pin driver for the query read-out bench
`timescale 1ns/10ps
module fqr_host_model
    import fqr_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              req_i,
    input  wire logic              wr_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [DATA_W-1:0] req_data_i,
    output fqr_ctl_s               ctl_o,
    output logic      [ADDR_W-1:0] addr_o,
    output logic      [DATA_W-1:0] dq_o
);
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ctl_o  <= 3'b111;
            addr_o <= '0;
            dq_o   <= '0;
        end
        else if (req_i)
        begin
            ctl_o  <= {1'b0, wr_i, !wr_i};
            addr_o <= req_addr_i;
            dq_o   <= req_data_i;
        end
        else
        begin
            // released lines toggle so a stale value never passes for live data
            ctl_o  <= 3'b111;
            addr_o <= ~addr_o;
            dq_o   <= ~dq_o;
        end
    end
endmodule : fqr_host_model

// File: fqr_part_mode.sv
// per-partition output mode, held until a new command changes it
`timescale 1ns/10ps
module fqr_part_mode
    import fqr_pkg::*;
#(
    parameter int N_PART = 16,
    parameter int PART_W = 4
)(
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              wr_en_i,
    input  wire logic [PART_W-1:0] wr_part_i,
    input  wire logic [7:0]        wr_cmd_i,
    input  wire logic [PART_W-1:0] rd_part_i,
    output fqr_mode_e              rd_mode_o
);

    fqr_mode_e mode_r [N_PART];

    function automatic fqr_mode_e decode_cmd(input logic [7:0] cmd, input fqr_mode_e cur);
        decode_cmd = cur;
        if (cmd == CMD_READ_ARRAY)
            decode_cmd = FQR_ARRAY;
        else if (cmd == CMD_QUERY || cmd == CMD_READ_ID)
            decode_cmd = FQR_QUERY;
        else if (cmd == CMD_READ_STATUS)
            decode_cmd = FQR_STATUS;
    endfunction : decode_cmd

    for (genvar p = 0; p < N_PART; p++)
    begin : g_part
        always_ff @(posedge clk_i)
        begin
            if (reset_i)
                mode_r[p] <= FQR_ARRAY;
            else if (wr_en_i && wr_part_i == PART_W'(p))
                mode_r[p] <= decode_cmd(wr_cmd_i, mode_r[p]);
        end
    end

    assign rd_mode_o = mode_r[rd_part_i];

endmodule : fqr_part_mode

// File: fqr_pkg.sv
// shared constants, types and command codes of the flash query read-out block
package fqr_pkg;

    localparam int ADDR_W     = 22;
    localparam int DATA_W     = 16;
    localparam int BLK_SHIFT  = 15;
    localparam int PART_SHIFT = 18;
    localparam int OFS_W      = 8;

    localparam logic [OFS_W-1:0] OFS_MAKER_ID   = 8'h00;
    localparam logic [OFS_W-1:0] OFS_PART_ID    = 8'h01;
    localparam logic [OFS_W-1:0] OFS_BLK_STATUS = 8'h02;
    localparam logic [OFS_W-1:0] OFS_RSVD_FIRST = 8'h04;
    localparam logic [OFS_W-1:0] OFS_RSVD_LAST  = 8'h0F;
    localparam logic [OFS_W-1:0] OFS_QUERY_ID   = 8'h10;
    localparam logic [OFS_W-1:0] OFS_PRI_CMDSET = 8'h13;
    localparam logic [OFS_W-1:0] OFS_PRI_PTR    = 8'h15;
    localparam logic [OFS_W-1:0] OFS_ALT_CMDSET = 8'h17;
    localparam logic [OFS_W-1:0] OFS_ALT_PTR    = 8'h19;
    localparam logic [OFS_W-1:0] OFS_SYS_IF     = 8'h1B;
    localparam logic [OFS_W-1:0] OFS_GEOMETRY   = 8'h27;

    localparam logic [7:0] SIG_CHAR_Q = 8'h51;
    localparam logic [7:0] SIG_CHAR_R = 8'h52;
    localparam logic [7:0] SIG_CHAR_Y = 8'h59;
    localparam logic [7:0] UPPER_FILL = 8'h00;

    localparam logic [15:0] PRI_CMDSET_ID  = 16'h0003;
    localparam logic [15:0] PRI_TABLE_PTR  = 16'h0039;
    localparam logic [15:0] ALT_CMDSET_ID  = 16'h0000;
    localparam logic [15:0] ALT_TABLE_PTR  = 16'h0000;

    localparam int LOCK_BIT     = 0;
    localparam int LOCKDOWN_BIT = 1;

    localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
    localparam logic [7:0] CMD_READ_ID     = 8'h90;
    localparam logic [7:0] CMD_QUERY       = 8'h98;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;

    typedef enum logic [1:0] {
        FQR_ARRAY  = 2'b00,
        FQR_QUERY  = 2'b01,
        FQR_STATUS = 2'b11
    } fqr_mode_e;

    typedef struct packed {
        logic [7:0] hi_byte;
        logic [7:0] lo_byte;
    } fqr_word_s;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fqr_ctl_s;

endpackage : fqr_pkg

// File: fqr_query_rom.sv
// constant query database: one byte per word offset
`timescale 1ns/10ps
module fqr_query_rom
    import fqr_pkg::*;
#(
    parameter logic [15:0] MAKER_ID = 16'h00A5,   // arbitrary value
    parameter logic [15:0] PART_ID  = 16'h005A,   // arbitrary value
    parameter logic [95:0] SYS_IF   = 96'h0003_0004_000A_0004_C6B4_1917
)(
    input  wire logic [OFS_W-1:0] ofs_i,
    output logic      [7:0]       byte_o
);

    // low byte of a multi-byte field sits at its lower offset
    function automatic logic [7:0] field_byte(input logic [15:0] field, input logic upper);
        field_byte = upper ? field[15:8] : field[7:0];
    endfunction : field_byte

    always_comb
    begin
        byte_o = 8'h00;
        if (ofs_i == OFS_MAKER_ID)
            byte_o = MAKER_ID[7:0];
        else if (ofs_i == OFS_PART_ID)
            byte_o = PART_ID[7:0];
        else if (ofs_i >= OFS_RSVD_FIRST && ofs_i <= OFS_RSVD_LAST)
            byte_o = 8'h00;
        else if (ofs_i == OFS_QUERY_ID)
            byte_o = SIG_CHAR_Q;
        else if (ofs_i == OFS_QUERY_ID + 8'h01)
            byte_o = SIG_CHAR_R;
        else if (ofs_i == OFS_QUERY_ID + 8'h02)
            byte_o = SIG_CHAR_Y;
        else if (ofs_i == OFS_PRI_CMDSET || ofs_i == OFS_PRI_CMDSET + 8'h01)
            byte_o = field_byte(PRI_CMDSET_ID, ofs_i != OFS_PRI_CMDSET);
        else if (ofs_i == OFS_PRI_PTR || ofs_i == OFS_PRI_PTR + 8'h01)
            byte_o = field_byte(PRI_TABLE_PTR, ~ofs_i[0]);
        else if (ofs_i == OFS_ALT_CMDSET || ofs_i == OFS_ALT_CMDSET + 8'h01)
            byte_o = field_byte(ALT_CMDSET_ID, ofs_i != OFS_ALT_CMDSET);
        else if (ofs_i == OFS_ALT_PTR || ofs_i == OFS_ALT_PTR + 8'h01)
            byte_o = field_byte(ALT_TABLE_PTR, ~ofs_i[0]);
        else if (ofs_i >= OFS_SYS_IF && ofs_i < OFS_GEOMETRY)
            byte_o = SYS_IF[8*(ofs_i - OFS_SYS_IF) +: 8];
    end

endmodule : fqr_query_rom
